// file: logic/pgcm_pkg.sv
// Package of offsets, fields, reset values and codes for the GPIO control map
package pgcm_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_CTRL   = 8'h00; // Wake mask, retention, cmds
    localparam logic [7:0] OFF_STATUS = 8'h04; // Machine state and flags
    localparam logic [7:0] OFF_FUNC   = 8'h08; // GPIO function select
    localparam logic [7:0] OFF_GPO    = 8'h0c; // GPIO output values
    localparam logic [7:0] OFF_GPI    = 8'h10; // Synchronised pin levels
    // Control register fields
    localparam int CTRL_LPW_UNMASK = 0;  // Low-power wake unmask
    localparam int CTRL_RET        = 1;  // Retention control level
    localparam int CTRL_RST_REL    = 2;  // Release main reset output
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000; // Wake masked
    localparam logic [31:0] FUNC_RST = 32'h0000_0000; // Default functions
    localparam logic [31:0] GPO_RST  = 32'h0000_0000;
    // Number of reassignable GPIOs
    localparam int NGPIO = 8;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Combined power state machine
    typedef enum logic [1:0] {
        PGCM_OFF    = 2'b00,
        PGCM_ACTIVE = 2'b01,
        PGCM_MCU    = 2'b10
    } pgcm_state_e;
    // Regulator mode of the first linear regulator
    localparam logic REG_MODE_LDO    = 1'b0; // 1.8 V regulating
    localparam logic REG_MODE_BYPASS = 1'b1; // 3.3 V bypass
endpackage

// file: logic/pgcm_top.sv
// Control-signal and GPIO-function logic of the dual controller pair
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.

// What this block does
// - Primary and secondary keep one shared state
// - Secondary enable follows primary internal regulator
// - Second wake input enters MCU-only state
// - Either first wake input enters ACTIVE state
// - Low-power wake masked until software unmasks
// - SD select pin is pulled-down input
// - Rising SD select edge bypasses regulator, 3.3V
// - Falling SD select edge regulates, 1.8V
// - Watchdog state latched, pin then reassignable
// - GPIOs come up in default function
// - Unneeded GPIOs software reconfigurable
// - Key signals work in low-power modes
module pgcm_top (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Pins
    input  wire logic              internal_regulator_output,
    input  wire logic              wake_active_input,
    input  wire logic              low_power_wake_input,
    input  wire logic              wake_mcu_only_input,
    input  wire logic              sd_voltage_select,
    input  wire logic              wdog_disable_pin,
    input  wire logic [pgcm_pkg::NGPIO-1:0] gpio_in,
    // Outputs
    output logic                   secondary_enable,
    output logic [1:0]             machine_state,
    output logic                   main_reset_output,
    output logic                   regulator_bypass,
    output logic                   sd_switch_pulse,
    output logic                   watchdog_enable,
    output logic                   memory_retention_control,
    output logic [pgcm_pkg::NGPIO-1:0] gpio_out,
    output logic [pgcm_pkg::NGPIO-1:0] gpio_oe
);

    // Every check below samples on the bus clock and sleeps in reset
    default clocking ast_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: two flops per asynchronous pin
    localparam int NS = 6 + pgcm_pkg::NGPIO;
    logic [NS-1:0] s1_q, s1_d;       // First stage, read only by second
    logic [NS-1:0] s2_q, s2_d;       // Second stage, safe to use
    logic          sd_prev_q, sd_prev_d; // Previous SD level for edges

    // Sync next values
    always_comb begin
        s1_d = {gpio_in, wdog_disable_pin, sd_voltage_select,
                wake_mcu_only_input, low_power_wake_input,
                wake_active_input, internal_regulator_output};
        s2_d = s1_q;
        sd_prev_d = s2_q[4];
    end

    // Sync registers; SD idles low as its pulldown does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q      <= '0;
            s2_q      <= '0;
            sd_prev_q <= 1'b0;
        end else begin
            s1_q      <= s1_d;
            s2_q      <= s2_d;
            sd_prev_q <= sd_prev_d;
        end
    end

    logic ldo_s, wk1_s, lpw_s, wk2_s, sd_s, wdd_s;
    assign ldo_s = s2_q[0];
    assign wk1_s = s2_q[1];
    assign lpw_s = s2_q[2];
    assign wk2_s = s2_q[3];
    assign sd_s  = s2_q[4];
    assign wdd_s = s2_q[5];

    logic sd_rise, sd_fall;
    assign sd_rise = sd_s & ~sd_prev_q;
    assign sd_fall = ~sd_s & sd_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers and AXI4-Lite slave state
    logic [31:0] ctrl_q, ctrl_d;      // Control bits
    logic [31:0] func_q, func_d;      // 1 = software function
    logic [31:0] gpo_q, gpo_d;        // Software output values
    logic        aw_q, aw_d;          // Write address held
    logic        w_q, w_d;            // Write data held
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bv_q, bv_d;
    logic [1:0]  br_q, br_d;
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;
    logic        awrdy_q, awrdy_d;    // Write address ready
    logic        wrdy_q, wrdy_d;      // Write data ready
    logic        arrdy_q, arrdy_d;    // Read address ready

    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // Mapped offset check
    function automatic logic mapped(input logic [7:0] a);
        return a == pgcm_pkg::OFF_CTRL || a == pgcm_pkg::OFF_STATUS ||
               a == pgcm_pkg::OFF_FUNC || a == pgcm_pkg::OFF_GPO ||
               a == pgcm_pkg::OFF_GPI;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Power state machine and latched watchdog
    pgcm_pkg::pgcm_state_e st_q, st_d; // One machine for both controllers
    logic        rst_q, rst_d;        // Main reset output level
    logic        wde_q, wde_d;        // Watchdog enable
    logic        byp_q, byp_d;        // Regulator bypass
    logic        pls_q, pls_d;        // Switch pulse
    logic        en2_q, en2_d;        // Secondary enable
    logic [pgcm_pkg::NGPIO-1:0] go_q, go_d, oe_q, oe_d;

    // AXI and register next values
    always_comb begin
        aw_d = aw_q;   w_d = w_q;   awa_d = awa_q;
        wd_d = wd_q;   ws_d = ws_q; bv_d = bv_q;  br_d = br_q;
        rv_d = rv_q;   rd_d = rd_q; rr_d = rr_q;
        ctrl_d = ctrl_q; func_d = func_q; gpo_d = gpo_q;
        // Address and data taken in either order
        if (s_axi_awvalid && awrdy_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        // Commit once both are held
        if (aw_q && w_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(awa_q) ? pgcm_pkg::RESP_OKAY
                                 : pgcm_pkg::RESP_SLVERR;
            case (awa_q)
                pgcm_pkg::OFF_CTRL: ctrl_d = merge(ctrl_q, wd_q, ws_q);
                pgcm_pkg::OFF_FUNC: func_d = merge(func_q, wd_q, ws_q);
                pgcm_pkg::OFF_GPO:  gpo_d  = merge(gpo_q, wd_q, ws_q);
                default: ;
            endcase
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        // Each ready only while its own channel holds nothing and no response waits
        awrdy_d = !aw_d && !bv_d;
        wrdy_d = !w_d && !bv_d;
        // Read
        if (s_axi_arvalid && arrdy_q) begin
            rv_d = 1'b1;
            rr_d = pgcm_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pgcm_pkg::OFF_CTRL:   rd_d = ctrl_q;
                pgcm_pkg::OFF_STATUS: rd_d = {24'h0, en2_q, byp_q, wde_q,
                                               rst_q, 2'h0, st_q};
                pgcm_pkg::OFF_FUNC:   rd_d = func_q;
                pgcm_pkg::OFF_GPO:    rd_d = gpo_q;
                pgcm_pkg::OFF_GPI:    rd_d = {{(32-pgcm_pkg::NGPIO){1'b0}},
                                               s2_q[NS-1:6]};
                default: begin
                    rd_d = 32'h0;
                    rr_d = pgcm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        arrdy_d = !rv_d; // One read in flight at a time
    end

    // Machine next values; MCU-only wake takes priority
    always_comb begin
        logic lp_ok;
        lp_ok = lpw_s & ctrl_q[pgcm_pkg::CTRL_LPW_UNMASK];
        st_d = st_q;
        en2_d = ldo_s;
        if (wk2_s) begin
            st_d = pgcm_pkg::PGCM_MCU;
        end else if (wk1_s || lp_ok) begin
            st_d = pgcm_pkg::PGCM_ACTIVE;
        end
        // Shared state reported to both controllers
        rst_d = rst_q | ctrl_q[pgcm_pkg::CTRL_RST_REL];
        // Capture strap on release edge, then hold
        wde_d = (!rst_q && rst_d) ? ~wdd_s : wde_q;
        byp_d = byp_q;
        if (sd_rise) byp_d = pgcm_pkg::REG_MODE_BYPASS;
        else if (sd_fall) byp_d = pgcm_pkg::REG_MODE_LDO;
        pls_d = sd_rise | sd_fall;
        // Default functions drive nothing until reassigned
        oe_d = func_q[pgcm_pkg::NGPIO-1:0];
        go_d = gpo_q[pgcm_pkg::NGPIO-1:0] & func_q[pgcm_pkg::NGPIO-1:0];
    end

    // All state registers but the input synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h0;
            wd_q <= 32'h0; ws_q <= 4'h0; bv_q <= 1'b0;
            br_q <= 2'h0; rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'h0;
            awrdy_q <= 1'b0; wrdy_q <= 1'b0; arrdy_q <= 1'b0;
            ctrl_q <= pgcm_pkg::CTRL_RST;
            func_q <= pgcm_pkg::FUNC_RST;
            gpo_q  <= pgcm_pkg::GPO_RST;
            st_q <= pgcm_pkg::PGCM_OFF;
            rst_q <= 1'b0; wde_q <= 1'b1; byp_q <= 1'b0;
            pls_q <= 1'b0; en2_q <= 1'b0;
            go_q <= '0; oe_q <= '0;
        end else begin
            aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d;
            wd_q <= wd_d; ws_q <= ws_d; bv_q <= bv_d;
            br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
            awrdy_q <= awrdy_d; wrdy_q <= wrdy_d; arrdy_q <= arrdy_d;
            ctrl_q <= ctrl_d; func_q <= func_d; gpo_q <= gpo_d;
            st_q <= st_d;
            rst_q <= rst_d; wde_q <= wde_d; byp_q <= byp_d;
            pls_q <= pls_d; en2_q <= en2_d;
            go_q <= go_d; oe_q <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the machine, the secondary enable, the SD edges and the watchdog latch
    sequence sd_rise_seq;
        !sd_prev_q && sd_s;
    endsequence
    sequence sd_fall_seq;
        sd_prev_q && !sd_s;
    endsequence
    // Main reset output going from held to released
    sequence release_seq;
        !rst_q ##1 rst_q;
    endsequence
    AST_MCU_WAKE: assert property (
        wk2_s |=> st_q == pgcm_pkg::PGCM_MCU)
        else $error("MCU-only wake did not reach MCU state");
    AST_ACTIVE_WAKE: assert property (
        !wk2_s && wk1_s |=> st_q == pgcm_pkg::PGCM_ACTIVE)
        else $error("Active wake did not reach ACTIVE state");
    // A masked low-power wake must not move the machine
    AST_LP_MASKED: assert property (
        !ctrl_q[pgcm_pkg::CTRL_LPW_UNMASK] && !wk2_s && !wk1_s
        |=> $stable(st_q))
        else $error("Masked low-power wake changed state");
    AST_SEC_ENABLE: assert property (
        1'b1 |=> en2_q == $past(ldo_s))
        else $error("Secondary enable lost regulator output");
    AST_SD_BYPASS: assert property (
        sd_rise_seq |=> byp_q == pgcm_pkg::REG_MODE_BYPASS)
        else $error("Rising SD select did not bypass");
    AST_SD_LDO: assert property (
        sd_fall_seq |=> byp_q == pgcm_pkg::REG_MODE_LDO)
        else $error("Falling SD select did not regulate");
    AST_SD_PULSE: assert property (
        sd_s != sd_prev_q |=> pls_q)
        else $error("SD edge gave no switch pulse");
    AST_SD_NO_PULSE: assert property (
        sd_s == sd_prev_q |=> !pls_q)
        else $error("Switch pulse without an SD edge");
    // Strap level is taken on the release cycle only
    AST_WDOG_CAPTURE: assert property (
        release_seq |-> wde_q == !$past(wdd_s))
        else $error("Watchdog strap not captured at release");
    AST_WDOG_HOLD: assert property (
        rst_q |=> $stable(wde_q))
        else $error("Watchdog enable moved after release");

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready  = wrdy_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign secondary_enable = en2_q;
    assign machine_state = st_q;
    assign main_reset_output = rst_q;
    assign regulator_bypass = byp_q;
    assign sd_switch_pulse = pls_q;
    assign watchdog_enable = wde_q;
    assign memory_retention_control = ctrl_q[pgcm_pkg::CTRL_RET];
    assign gpio_out = go_q;
    assign gpio_oe = oe_q;

endmodule // pgcm_top

// file: test/pgcm_proc_model.sv
// Processor-side pin model that drives the block's control inputs
module pgcm_proc_model (
    // Clock
    input  wire logic       aclk,
    // Levels asked of the processor by the bench
    input  wire logic [5:0] req,
    input  wire logic       sd_drive,
    // Pins into the block
    output logic            internal_regulator_output,
    output logic            wake_active_input,
    output logic            low_power_wake_input,
    output logic            wake_mcu_only_input,
    output logic            sd_voltage_select,
    output logic            wdog_disable_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // Pins move one edge after a request, as a real driver would
    always @(posedge aclk) begin
        internal_regulator_output <= req[0];
        wake_active_input         <= req[1];
        low_power_wake_input      <= req[2];
        wake_mcu_only_input       <= req[3];
        // Released line settles low through the internal pulldown
        sd_voltage_select         <= sd_drive & req[4];
        // Strap held high before reset release when wanted
        wdog_disable_pin          <= req[5];
    end
endmodule // pgcm_proc_model

// file: test/pmic_gpio_control_map_tb.sv
// Self-checking bench for the GPIO control map block
module pmic_gpio_control_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    logic        aclk = 1'b0, aresetn = 1'b0;   // 50 MHz, active low
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;   // Bus addresses
    logic [31:0] wdata = 32'h0, rdata, rd;           // Bus data
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp, mstate;
    logic [5:0]  req = 6'h00;                       // Pin levels asked
    logic        sd_drive = 1'b0;                   // Processor drives SD
    logic [7:0]  gin = 8'h00, gout, goe, g, h;      // GPIO pins
    logic        p0, p1, p2, p3, p4, p5;            // Model pins
    logic        sec, rsto, byp, pulse, wde, ret;   // Block outputs
    logic [6:0]  obs;                               // Packed outputs
    int          error_cnt = 0, total_checks = 0, cyc = 0, pulses = 0;
    int          exp_ctrl = 0;                      // Control word model
    int          exp_sd[$];                         // Modes per SD edge
    assign obs = {mstate, sec, rsto, byp, wde, ret};
    ////////////////////////////////////////////////////////////////////////
    // Clock, pulse counter and hang guard
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (pulse === 1'b1) pulses++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    pgcm_proc_model PROC (.aclk(aclk), .req(req), .sd_drive(sd_drive),
        .internal_regulator_output(p0), .wake_active_input(p1),
        .low_power_wake_input(p2), .wake_mcu_only_input(p3),
        .sd_voltage_select(p4), .wdog_disable_pin(p5));
    pgcm_top DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .internal_regulator_output(p0), .wake_active_input(p1),
        .low_power_wake_input(p2), .wake_mcu_only_input(p3),
        .sd_voltage_select(p4), .wdog_disable_pin(p5), .gpio_in(gin),
        .secondary_enable(sec), .machine_state(mstate),
        .main_reset_output(rsto), .regulator_bypass(byp),
        .sd_switch_pulse(pulse), .watchdog_enable(wde),
        .memory_retention_control(ret), .gpio_out(gout), .gpio_oe(goe));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Write: address and data offered together, each freed when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, pgcm_pkg::RESP_OKAY, "write resp");
    endtask
    task automatic rdw(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask
    // Bounded wait for masked outputs to reach a level
    task automatic wait_obs(input logic [6:0] m, v, input string what);
        int n;
        n = 0;
        while ((obs & m) !== v && n < 64) begin
            @(posedge aclk);
            n++;
        end
        check({25'h0, obs & m}, {25'h0, v}, what);
    endtask
    task automatic pins(input logic [5:0] v);
        @(posedge aclk);
        req <= v;
        // Model, two sync stages and the state flop all settle
        repeat (6) @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(69));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values and an unmapped place
        rdw(pgcm_pkg::OFF_CTRL);
        check(rd, pgcm_pkg::CTRL_RST, "ctrl reset");
        rdw(pgcm_pkg::OFF_FUNC);
        check(rd, pgcm_pkg::FUNC_RST, "func reset");
        rdw(8'h40);
        check(resp, pgcm_pkg::RESP_SLVERR, "unmapped");
        wait_obs(7'h0e, 7'h02, "outs reset");
        $display("test reset done");
        // Secondary enable follows the regulator output
        wait_obs(7'h10, 7'h00, "sec low");
        pins(6'h01);
        wait_obs(7'h10, 7'h10, "sec high");
        // Wake inputs, masked low-power wake, MCU-only priority
        pins(6'h09);
        wait_obs(7'h60, {pgcm_pkg::PGCM_MCU, 5'h0}, "mcu");
        pins(6'h05);
        wait_obs(7'h60, {pgcm_pkg::PGCM_MCU, 5'h0}, "lp masked");
        exp_ctrl = 1 << pgcm_pkg::CTRL_LPW_UNMASK;
        wr(pgcm_pkg::OFF_CTRL, exp_ctrl);
        pins(6'h01);
        pins(6'h05);
        wait_obs(7'h60, {pgcm_pkg::PGCM_ACTIVE, 5'h0}, "lp act");
        pins(6'h09);
        pins(6'h03);
        wait_obs(7'h60, {pgcm_pkg::PGCM_ACTIVE, 5'h0}, "act");
        pins(6'h0b);
        wait_obs(7'h60, {pgcm_pkg::PGCM_MCU, 5'h0}, "both");
        $display("test wake done");
        // SD select edges, then release onto the pulldown
        sd_drive <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            exp_sd.push_back((i % 2 == 0) ? pgcm_pkg::REG_MODE_BYPASS
                                          : pgcm_pkg::REG_MODE_LDO);
            if (i < 3) pins((i % 2 == 0) ? 6'h11 : 6'h01);
            else sd_drive <= 1'b0;
            wait_obs(7'h04, {4'h0, exp_sd.pop_front(), 2'h0}, "sd");
            // Let the pulse counter see the last pulse first
            repeat (2) @(posedge aclk);
            check(pulses, i + 1, "one pulse");
        end
        $display("test sd done");
        // Watchdog strap captured at reset release, pin then free
        pins(6'h21);
        exp_ctrl = exp_ctrl | (1 << pgcm_pkg::CTRL_RST_REL);
        wr(pgcm_pkg::OFF_CTRL, exp_ctrl);
        wait_obs(7'h0a, 7'h08, "wdog off");
        pins(6'h01);
        repeat (16) @(posedge aclk);
        wait_obs(7'h0a, 7'h08, "wdog held");
        // Retention level set by software at runtime
        exp_ctrl = exp_ctrl | (1 << pgcm_pkg::CTRL_RET);
        wr(pgcm_pkg::OFF_CTRL, exp_ctrl);
        wait_obs(7'h01, 7'h01, "retention");
        rdw(pgcm_pkg::OFF_CTRL);
        check(rd, exp_ctrl, "ctrl read");
        $display("test wdog done");
        // Random GPIO reassignment and input levels
        g = 8'($urandom);
        wr(pgcm_pkg::OFF_FUNC, {24'h0, g});
        h = 8'($urandom);
        wr(pgcm_pkg::OFF_GPO, {24'h0, h});
        gin <= 8'($urandom);
        repeat (8) @(posedge aclk);
        check({24'h0, goe}, {24'h0, g}, "oe");
        check({24'h0, gout}, {24'h0, h & g}, "gpo");
        rdw(pgcm_pkg::OFF_GPI);
        check(rd, {24'h0, gin}, "gpi");
        $display("test gpio done");
        tally_and_finish();
    end
endmodule // pmic_gpio_control_map_tb
